// ---- bench/drs_master_model.sv ----
`timescale 1ns/1ps
module drs_master_model
    import drs_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic [3:0]           dly_i,
    input  wire logic [DRS_N_REQ-1:0] go_i,
    input  wire logic [DRS_N_REQ-1:0] start_i,
    input  wire logic [DRS_N_REQ-1:0] done_i,
    output logic      [DRS_N_REQ-1:0] req_o,
    output logic      [DRS_N_REQ-1:0] fin_o
);
    logic [DRS_N_REQ-1:0] seen_q;
    logic [DRS_N_REQ-1:0] st_q;
    logic [3:0]           cnt_q [DRS_N_REQ];
    initial begin
        req_o = '0;
        fin_o = '0;
        seen_q = '0;
        st_q = '0;
        for (int i = 0; i < DRS_N_REQ; i++) cnt_q[i] = 4'h0;
    end
    always @(posedge clk_i) begin
        for (int i = 0; i < DRS_N_REQ; i++) begin
            req_o[i] <= go_i[i] & ~done_i[i] & ~seen_q[i];
            seen_q[i] <= (seen_q[i] | done_i[i]) & go_i[i];
            st_q[i] <= start_i[i];
            fin_o[i] <= (cnt_q[i] == 4'h1);
            if (start_i[i] && !st_q[i]) begin
                cnt_q[i] <= dly_i;
            end else if (cnt_q[i] != 4'h0) begin
                cnt_q[i] <= cnt_q[i] - 4'h1;
            end
        end
    end
endmodule

// ---- bench/drs_status_flags_asserts.sv ----
`timescale 1ns/1ps
module drs_status_flags_chk
    import drs_pkg::*;
(
    input wire logic                  REF_CLK_I,
    input wire logic                  ARST_N_I,
    input wire logic                  FWD_RUN_I,
    input wire logic                  REV_RUN_I,
    input wire logic                  SPEED_REACHED_I,
    input wire logic                  OVERLOAD_ALARM_I,
    input wire logic                  IN_POSITION_I,
    input wire logic                  POSITIONING_BUSY_I,
    input wire logic                  HOMING_COMPLETE_I,
    input wire logic                  HOMING_FAILED_I,
    input wire logic                  FAULT_TRIP_I,
    input wire logic                  MONITOR_REQUEST_I,
    input wire logic                  VOL_STORED_I,
    input wire logic                  EXEC_FINISHED_I,
    input wire logic                  EXEC_START_O,
    input wire logic [DRS_DATA_W-1:0] STATUS_WORD_O
);
    logic [2:0] up_r;
    logic       up;
    // internal reset trails the pin by two flops, so wait it out
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            up_r <= 3'h0;
        end else if (up_r != 3'h7) begin
            up_r <= up_r + 3'h1;
        end
    end
    assign up = (up_r == 3'h7);
    default clocking @(posedge REF_CLK_I);
    endclocking
    default disable iff (!ARST_N_I);
    a_fwd_flag: assert property (up |-> STATUS_WORD_O[0] == $past(FWD_RUN_I & ~REV_RUN_I))
        else $error("forward flag wrong");
    a_rev_flag: assert property (up |-> STATUS_WORD_O[1] == $past(REV_RUN_I & ~FWD_RUN_I))
        else $error("reverse flag wrong");
    a_fault_flag: assert property (up |-> STATUS_WORD_O[26] == $past(FAULT_TRIP_I))
        else $error("fault flag wrong");
    a_ready_on_fault: assert property (up && $past(FAULT_TRIP_I) |-> !STATUS_WORD_O[27])
        else $error("ready high during fault");
    a_fixed_alarm: assert property (up |-> STATUS_WORD_O[4:3] ==
        $past({OVERLOAD_ALARM_I, SPEED_REACHED_I})) else $error("fixed alarm bits wrong");
    a_fixed_pos: assert property (up |-> STATUS_WORD_O[31:28] == $past({HOMING_FAILED_I,
        HOMING_COMPLETE_I, POSITIONING_BUSY_I, IN_POSITION_I})) else $error("position bits wrong");
    a_mon_clear: assert property (up && $fell(MONITOR_REQUEST_I) |-> ##[1:6] !STATUS_WORD_O[12])
        else $error("monitor ack not cleared");
    a_vol_after_store: assert property (up && $rose(STATUS_WORD_O[13]) |-> $past(VOL_STORED_I, 2))
        else $error("volatile done without store");
    a_exec_after_done: assert property (up && $rose(STATUS_WORD_O[15]) |-> $past(EXEC_FINISHED_I, 2))
        else $error("exec done without finish");
    a_exec_pulse: assert property (EXEC_START_O |=> !EXEC_START_O)
        else $error("exec start not one cycle");
endmodule
bind drs_status_flags drs_status_flags_chk CHK (
    .REF_CLK_I(REF_CLK_I), .ARST_N_I(ARST_N_I), .FWD_RUN_I(FWD_RUN_I), .REV_RUN_I(REV_RUN_I),
    .SPEED_REACHED_I(SPEED_REACHED_I), .OVERLOAD_ALARM_I(OVERLOAD_ALARM_I),
    .IN_POSITION_I(IN_POSITION_I), .POSITIONING_BUSY_I(POSITIONING_BUSY_I),
    .HOMING_COMPLETE_I(HOMING_COMPLETE_I), .HOMING_FAILED_I(HOMING_FAILED_I),
    .FAULT_TRIP_I(FAULT_TRIP_I), .MONITOR_REQUEST_I(MONITOR_REQUEST_I),
    .VOL_STORED_I(VOL_STORED_I), .EXEC_FINISHED_I(EXEC_FINISHED_I),
    .EXEC_START_O(EXEC_START_O), .STATUS_WORD_O(STATUS_WORD_O)
);

// ---- bench/drs_status_flags_test.sv ----
`timescale 1ns/1ps
module drs_status_flags_test
    import drs_pkg::*;
;
    logic        clk, rst_n, wr, rd, irq, mref, vst, pst, est;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, sw, d;
    logic [3:0]  req, fin, go, dly;
    logic [9:0]  pin;
    logic [14:0] fsrc;
    int          err_count, comparisons;
    drs_status_flags DUT (
        .REF_CLK_I(clk), .ARST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq), .MONITOR_REQUEST_I(req[0]),
        .VOLATILE_WRITE_REQUEST_I(req[1]), .PERSISTENT_WRITE_REQUEST_I(req[2]),
        .INSTR_EXEC_REQUEST_I(req[3]), .MON_LOADED_I(fin[0]), .VOL_STORED_I(fin[1]),
        .PERS_STORED_I(fin[2]), .EXEC_FINISHED_I(fin[3]), .MON_REFRESH_O(mref),
        .VOL_WRITE_START_O(vst), .PERS_WRITE_START_O(pst), .EXEC_START_O(est),
        .FWD_RUN_I(pin[0]), .REV_RUN_I(pin[1]), .SPEED_REACHED_I(pin[2]),
        .OVERLOAD_ALARM_I(pin[3]), .IN_POSITION_I(pin[4]), .POSITIONING_BUSY_I(pin[5]),
        .HOMING_COMPLETE_I(pin[6]), .HOMING_FAILED_I(pin[7]), .FAULT_TRIP_I(pin[8]),
        .SETUP_DONE_I(pin[9]), .FUNC_SRC_I(fsrc), .STATUS_WORD_O(sw)
    );
    drs_master_model PM (
        .clk_i(clk), .dly_i(dly), .go_i(go), .start_i({est, pst, vst, mref}),
        .done_i(sw[15:12]), .req_o(req), .fin_o(fin)
    );
    always #2.5 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrt(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdt(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic wait_bit(input int b, input logic v);
        int n;
        n = 0;
        while (sw[b] !== v && n < 60) begin
            @(posedge clk);
            n++;
        end
        #1;
        chk(32'(sw[b]), 32'(v));
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #200us;
        err_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        {clk, rst_n, wr, rd, addr, wdata, go, fsrc} = '0;
        dly = 4'h1;
        pin = 10'h200;
        err_count = 0;
        comparisons = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rdt(8'h04, d); chk(d, 32'hfffff210);
        rdt(8'h08, d); chk(d, 32'h000000ff);
        rdt(8'h10, d); chk(d, 32'h0);
        rdt(8'h20, d); chk(d, 32'h0);
        chk(sw, 32'h08000000);
        $display("test reset values finished");
        @(posedge clk);
        pin <= 10'h255;
        fsrc <= 15'h5;
        settle(); chk(sw, 32'h5800008d);
        rdt(8'h00, d); chk(d, 32'h5800008d);
        @(posedge clk);
        pin <= 10'h2aa;
        settle(); chk(sw, 32'ha8000096);
        @(posedge clk);
        pin <= 10'h203;
        settle(); chk(sw, 32'h08000084);
        $display("test fixed bits finished");
        @(posedge clk);
        fsrc <= 15'h2;
        wrt(8'h04, 32'hffff1021);
        wrt(8'h08, 32'h000000f1);
        wrt(8'h00, 32'hffffffff);
        pin <= 10'h200;
        settle(); chk(sw, 32'h08000424);
        rdt(8'h04, d); chk(d, 32'hffff1021);
        $display("test assignment finished");
        wrt(8'h0c, 32'h3f);
        wrt(8'h10, 32'h3f);
        for (int i = 0; i < DRS_N_REQ; i++) begin
            @(posedge clk);
            dly <= 4'(2 * i + 1);
            go[i] <= 1'b1;
            wait_bit(12 + i, 1'b1);
            if (i == 0) chk(32'(mref), 32'h1);
            // request still held in sync when done is seen, handshake no longer busy
            rdt(8'h14, d);
            chk(d, 32'h1 << i);
            settle(); chk(32'(irq), 32'h1);
            wait_bit(12 + i, 1'b0);
            @(posedge clk);
            go[i] <= 1'b0;
            rdt(8'h0c, d); chk(d, 32'h4 << i);
            wrt(8'h0c, d);
            settle(); chk(32'(irq), 32'h0);
        end
        $display("test handshakes finished");
        wrt(8'h10, 32'h0);
        pin <= 10'h300;
        settle(); chk(32'(sw[26]), 32'h1);
        chk(32'(sw[27]), 32'h0);
        chk(32'(irq), 32'h0);
        wrt(8'h10, 32'h1);
        settle(); chk(32'(irq), 32'h1);
        @(posedge clk);
        pin <= 10'h200;
        wrt(8'h0c, 32'h1);
        settle(); chk(32'(irq), 32'h0);
        chk(32'(sw[27]), 32'h1);
        $display("test fault finished");
        tally_and_finish();
    end
endmodule

// ---- src/drs_handshake.sv ----
`timescale 1ns/1ps
module drs_handshake
    import drs_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic req_i,
    input  wire logic done_i,
    output logic      start_o,
    output logic      busy_o,
    output logic      ack_o
);
    typedef struct packed {
        drs_hs_state_t st;
        logic          req_d;
    } drs_hs_reg_t;

    drs_hs_reg_t r;
    drs_hs_reg_t n;
    logic        rise;

    assign rise = req_i & ~r.req_d;

    always_comb begin
        n       = r;
        n.req_d = req_i;
        unique case (r.st)
            DRS_HS_IDLE: begin
                if (rise) begin
                    n.st = DRS_HS_WAIT;
                end
            end
            // a request dropped before completion abandons the job
            DRS_HS_WAIT: begin
                if (!req_i) begin
                    n.st = DRS_HS_IDLE;
                end else if (done_i) begin
                    n.st = DRS_HS_ACK;
                end
            end
            DRS_HS_ACK: begin
                if (!req_i) begin
                    n.st = DRS_HS_IDLE;
                end
            end
            default: begin
                n.st = DRS_HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '{st: DRS_HS_IDLE, req_d: 1'b0};
        end else begin
            r <= n;
        end
    end

    // start only on a fresh edge, so a held request never restarts
    assign start_o = rise & (r.st == DRS_HS_IDLE);
    assign busy_o  = (r.st == DRS_HS_WAIT);
    assign ack_o   = (r.st == DRS_HS_ACK);
endmodule

// ---- src/drs_pkg.sv ----
package drs_pkg;

    // register bus
    localparam int         DRS_ADDR_W       = 8;
    localparam int         DRS_DATA_W       = 32;
    localparam logic [7:0] DRS_OFS_STATUS   = 8'h00;
    localparam logic [7:0] DRS_OFS_SEL_LO   = 8'h04;
    localparam logic [7:0] DRS_OFS_SEL_HI   = 8'h08;
    localparam logic [7:0] DRS_OFS_IRQ_ST   = 8'h0c;
    localparam logic [7:0] DRS_OFS_IRQ_MASK = 8'h10;
    localparam logic [7:0] DRS_OFS_REQ      = 8'h14;

    // status word bit positions
    localparam int DRS_BIT_FWD    = 0;
    localparam int DRS_BIT_REV    = 1;
    localparam int DRS_BIT_SPEED  = 3;
    localparam int DRS_BIT_OVLD   = 4;
    localparam int DRS_BIT_ACK0   = 12;
    localparam int DRS_BIT_FAULT  = 26;
    localparam int DRS_BIT_READY  = 27;
    localparam int DRS_BIT_INPOS  = 28;
    localparam int DRS_BIT_PBUSY  = 29;
    localparam int DRS_BIT_HOMED  = 30;
    localparam int DRS_BIT_HFAIL  = 31;

    // assignable outputs: a, b, c, net 1..4, digital 0..2
    localparam int DRS_N_ASG = 10;
    localparam int DRS_SEL_W = 4;
    localparam int DRS_ASG_POS [DRS_N_ASG] = '{2, 6, 7, 5, 8, 22, 23, 9, 10, 11};

    // function codes; sources index the function bus
    localparam logic [3:0] DRS_FN_RUN   = 4'h0;
    localparam logic [3:0] DRS_FN_FREQ  = 4'h1;
    localparam logic [3:0] DRS_FN_FAULT = 4'h2;
    localparam logic [3:0] DRS_FN_NONE  = 4'hf;
    localparam int         DRS_FUNC_N   = 15;
    localparam logic [DRS_N_ASG*DRS_SEL_W-1:0] DRS_SEL_RST =
        {DRS_FN_NONE, DRS_FN_NONE, DRS_FN_NONE, DRS_FN_NONE, DRS_FN_NONE,
         DRS_FN_NONE, DRS_FN_NONE, DRS_FN_FAULT, DRS_FN_FREQ, DRS_FN_RUN};

    // request handshakes
    localparam int DRS_N_REQ    = 4;
    localparam int DRS_REQ_MON  = 0;
    localparam int DRS_REQ_VOL  = 1;
    localparam int DRS_REQ_PERS = 2;
    localparam int DRS_REQ_EXEC = 3;

    // interrupt events: fault, ready, then one per handshake done
    localparam int         DRS_IRQ_W     = 6;
    localparam int         DRS_IRQ_FAULT = 0;
    localparam int         DRS_IRQ_READY = 1;
    localparam int         DRS_IRQ_ACK0  = 2;
    localparam logic [5:0] DRS_MASK_RST  = 6'h00;

    typedef enum logic [1:0] {
        DRS_HS_IDLE = 2'b00,
        DRS_HS_WAIT = 2'b01,
        DRS_HS_ACK  = 2'b11
    } drs_hs_state_t;

endpackage

// ---- src/drs_status_flags.sv ----
`timescale 1ns/1ps
//Contract
// - forward flag high only while motor runs forward
// - reverse flag high only while motor runs in reverse
// - monitor ack set after values loaded, cleared when request drops
// - volatile write done set after store, cleared when request drops
// - persistent write done set after both stores, cleared on request low
// - execution done set after all codes processed, cleared on request low
// - fault flag set while a protective function is tripped
// - ready set after setup completes, forced low on fault
// - four positioning signals on fixed bits
// - three selectable outputs default to running, freq detect, fault
// - four net and three digital outputs default to no function
// - monitored values refresh continuously while monitor request is high
module drs_status_flags
    import drs_pkg::*;
#(
    parameter int FUNC_N = DRS_FUNC_N
) (
    input  wire logic                  REF_CLK_I,
    input  wire logic                  ARST_N_I,
    input  wire logic [DRS_ADDR_W-1:0] ADDR_I,
    input  wire logic [DRS_DATA_W-1:0] WDATA_I,
    input  wire logic                  WR_I,
    input  wire logic                  RD_I,
    output logic      [DRS_DATA_W-1:0] RDATA_O,
    output logic                       IRQ_O,
    input  wire logic                  MONITOR_REQUEST_I,
    input  wire logic                  VOLATILE_WRITE_REQUEST_I,
    input  wire logic                  PERSISTENT_WRITE_REQUEST_I,
    input  wire logic                  INSTR_EXEC_REQUEST_I,
    input  wire logic                  MON_LOADED_I,
    input  wire logic                  VOL_STORED_I,
    input  wire logic                  PERS_STORED_I,
    input  wire logic                  EXEC_FINISHED_I,
    output logic                       MON_REFRESH_O,
    output logic                       VOL_WRITE_START_O,
    output logic                       PERS_WRITE_START_O,
    output logic                       EXEC_START_O,
    input  wire logic                  FWD_RUN_I,
    input  wire logic                  REV_RUN_I,
    input  wire logic                  SPEED_REACHED_I,
    input  wire logic                  OVERLOAD_ALARM_I,
    input  wire logic                  IN_POSITION_I,
    input  wire logic                  POSITIONING_BUSY_I,
    input  wire logic                  HOMING_COMPLETE_I,
    input  wire logic                  HOMING_FAILED_I,
    input  wire logic                  FAULT_TRIP_I,
    input  wire logic                  SETUP_DONE_I,
    input  wire logic [FUNC_N-1:0]     FUNC_SRC_I,
    output logic      [DRS_DATA_W-1:0] STATUS_WORD_O
);
    // codes at or above FUNC_N read as no function; the none code must stay out
    if (FUNC_N < 3 || FUNC_N > int'(DRS_FN_NONE)) begin : g_bad_func_n
        $error("FUNC_N out of range");
    end

    typedef struct packed {
        logic [DRS_DATA_W-1:0]                stat;
        logic [DRS_N_ASG-1:0][DRS_SEL_W-1:0] sel;
        logic [DRS_IRQ_W-1:0]                irq_st;
        logic [DRS_IRQ_W-1:0]                irq_mask;
        logic [DRS_IRQ_W-1:0]                ev_d;
        logic                                setup_seen;
        logic [DRS_DATA_W-1:0]               rdata;
    } drs_reg_t;

    drs_reg_t             r;
    drs_reg_t             n;
    logic [1:0]           rst_sync_r;
    logic                 rst_n;
    logic [DRS_N_REQ-1:0] req_raw;
    logic [DRS_N_REQ-1:0] req_s;
    logic [DRS_N_REQ-1:0] done_v;
    logic [DRS_N_REQ-1:0] start_v;
    logic [DRS_N_REQ-1:0] busy_v;
    logic [DRS_N_REQ-1:0] ack_v;
    logic [DRS_N_ASG-1:0] asg;
    logic                 ready;
    logic [DRS_IRQ_W-1:0] ev;

    // reset enters asynchronously, leaves on the clock
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    assign req_raw = {INSTR_EXEC_REQUEST_I, PERSISTENT_WRITE_REQUEST_I,
                      VOLATILE_WRITE_REQUEST_I, MONITOR_REQUEST_I};
    assign done_v  = {EXEC_FINISHED_I, PERS_STORED_I, VOL_STORED_I, MON_LOADED_I};

    // request bits come from the network side, another timing domain
    drs_sync #(
        .W (DRS_N_REQ)
    ) u_req_sync (
        .clk_i   (REF_CLK_I),
        .rst_n_i (rst_n),
        .d_i     (req_raw),
        .q_o     (req_s)
    );

    for (genvar k = 0; k < DRS_N_REQ; k++) begin : g_hs
        drs_handshake u_hs (
            .clk_i   (REF_CLK_I),
            .rst_n_i (rst_n),
            .req_i   (req_s[k]),
            .done_i  (done_v[k]),
            .start_o (start_v[k]),
            .busy_o  (busy_v[k]),
            .ack_o   (ack_v[k])
        );
    end

    assign MON_REFRESH_O      = req_s[DRS_REQ_MON];
    assign VOL_WRITE_START_O  = start_v[DRS_REQ_VOL];
    assign PERS_WRITE_START_O = start_v[DRS_REQ_PERS];
    assign EXEC_START_O       = start_v[DRS_REQ_EXEC];

    for (genvar k = 0; k < DRS_N_ASG; k++) begin : g_asg
        assign asg[k] = (r.sel[k] < FUNC_N) ? FUNC_SRC_I[r.sel[k]] : 1'b0;
    end

    // ready after setup, low on fault
    assign ready = r.setup_seen & ~FAULT_TRIP_I;

    assign ev = {ack_v, ready, FAULT_TRIP_I};

    always_comb begin
        n            = r;
        n.rdata      = '0;
        n.ev_d       = ev;
        n.setup_seen = r.setup_seen | SETUP_DONE_I;

        n.stat = '0;
        n.stat[DRS_BIT_FWD]   = FWD_RUN_I & ~REV_RUN_I;
        n.stat[DRS_BIT_REV]   = REV_RUN_I & ~FWD_RUN_I;
        n.stat[DRS_BIT_SPEED] = SPEED_REACHED_I;
        n.stat[DRS_BIT_OVLD]  = OVERLOAD_ALARM_I;
        n.stat[DRS_BIT_INPOS] = IN_POSITION_I;
        n.stat[DRS_BIT_PBUSY] = POSITIONING_BUSY_I;
        n.stat[DRS_BIT_HOMED] = HOMING_COMPLETE_I;
        n.stat[DRS_BIT_HFAIL] = HOMING_FAILED_I;
        n.stat[DRS_BIT_FAULT] = FAULT_TRIP_I;
        n.stat[DRS_BIT_READY] = ready;
        n.stat[DRS_BIT_ACK0 +: DRS_N_REQ] = ack_v;
        for (int k = 0; k < DRS_N_ASG; k++) begin
            n.stat[DRS_ASG_POS[k]] = asg[k];
        end

        // sticky events; a new event beats a same-cycle clear
        if (WR_I && ADDR_I == DRS_OFS_IRQ_ST) begin
            n.irq_st = r.irq_st & ~WDATA_I[DRS_IRQ_W-1:0];
        end
        n.irq_st = n.irq_st | (ev & ~r.ev_d);

        if (WR_I) begin
            unique case (ADDR_I)
                DRS_OFS_SEL_LO: begin
                    n.sel[7:0] = WDATA_I;
                end
                DRS_OFS_SEL_HI: begin
                    n.sel[9:8] = WDATA_I[7:0];
                end
                DRS_OFS_IRQ_MASK: begin
                    n.irq_mask = WDATA_I[DRS_IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // unmapped reads return zero
        if (RD_I) begin
            unique case (ADDR_I)
                DRS_OFS_STATUS: begin
                    n.rdata = r.stat;
                end
                DRS_OFS_SEL_LO: begin
                    n.rdata = r.sel[7:0];
                end
                DRS_OFS_SEL_HI: begin
                    n.rdata = {24'h000000, r.sel[9:8]};
                end
                DRS_OFS_IRQ_ST: begin
                    n.rdata = {26'h0, r.irq_st};
                end
                DRS_OFS_IRQ_MASK: begin
                    n.rdata = {26'h0, r.irq_mask};
                end
                DRS_OFS_REQ: begin
                    n.rdata = {24'h000000, busy_v, req_s};
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            r          <= '0;
            r.sel      <= DRS_SEL_RST;
            r.irq_mask <= DRS_MASK_RST;
        end else begin
            r <= n;
        end
    end

    assign RDATA_O       = r.rdata;
    assign STATUS_WORD_O = r.stat;
    assign IRQ_O         = |(r.irq_st & r.irq_mask);
endmodule

// ---- src/drs_sync.sv ----
`timescale 1ns/1ps
module drs_sync
    import drs_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } drs_sync_reg_t;

    drs_sync_reg_t r;
    drs_sync_reg_t n;

    // first stage feeds only the second
    always_comb begin
        n      = r;
        n.meta = d_i;
        n.q    = r.meta;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign q_o = r.q;
endmodule
